// ==== verilog/adcc_pkg.sv ====
// Constants, carriers and register map for the converter control block.
// Assumes a single 25 MHz core clock and an 8-bit software register port.
package adcc_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] OFS_CTRL0   = 3'h0;
    localparam logic [2:0] OFS_CTRL1   = 3'h1;
    localparam logic [2:0] OFS_CTRL2   = 3'h2;
    localparam logic [2:0] OFS_RES_HI  = 3'h3;
    localparam logic [2:0] OFS_RES_LO  = 3'h4;
    localparam logic [2:0] OFS_IRQ     = 3'h5;
    localparam logic [2:0] OFS_PINFUNC = 3'h6;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL0_START_BIT  = 7;
    localparam int CTRL0_BUSY_BIT   = 6;
    localparam int CTRL0_PWR_BIT    = 5;
    localparam int CTRL0_FMT_BIT    = 4;
    localparam int CTRL0_CHAN_LSB   = 0;
    localparam int CTRL1_SRC_LSB    = 4;
    localparam int CTRL1_CLK_LSB    = 0;
    localparam int CTRL2_PGAEN_BIT  = 7;
    localparam int CTRL2_PGA_INPUT_SELECT_BIT  = 4;
    localparam int CTRL2_REF_LSB    = 2;
    localparam int CTRL2_GAIN_LSB   = 0;
    localparam int IRQ_FLAG_BIT     = 0;
    localparam int IRQ_ADE_BIT      = 1;
    localparam int IRQ_EMI_BIT      = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CTRL0   = 8'h00;
    localparam logic [7:0] RST_CTRL1   = 8'h00;
    localparam logic [7:0] RST_CTRL2   = 8'h00;
    localparam logic [7:0] RST_PINFUNC = 8'h00;

    // ----------------------------------------------------------------
    // Timing counts in converter clocks
    // ----------------------------------------------------------------
    localparam logic [4:0] SAMPLE_CYCLES = 5'h04;
    localparam logic [4:0] CONV_CYCLES   = 5'h0C;
    localparam logic [4:0] TOTAL_CYCLES  = SAMPLE_CYCLES + CONV_CYCLES;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ADCC_REF_SUPPLY, ADCC_REF_PIN, ADCC_REF_PGA, ADCC_REF_NONE
    } adcc_ref_t;

    typedef enum logic [3:0] {
        ADCC_IN_EXT, ADCC_IN_SUP1, ADCC_IN_SUP2, ADCC_IN_SUP4,
        ADCC_IN_PGA1, ADCC_IN_PGA2, ADCC_IN_PGA4,
        ADCC_IN_AMP0, ADCC_IN_AMP1, ADCC_IN_GND
    } adcc_in_t;

    // Software register port
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } adcc_bus_t;

    // Analog routing controls toward the converter core
    typedef struct packed {
        adcc_ref_t  ref_sel;
        logic       ref_pin_en;
        logic       pga_en;
        logic       pga_from_bandgap;
        logic       pga_pin_en;
        logic [1:0] pga_gain;
        adcc_in_t   in_sel;
        logic       ext_path_en;
        logic [7:0] ext_chan_onehot;
        logic       power_on;
        logic       sample;
    } adcc_route_t;

endpackage

// ==== verilog/adcc_top.sv ====
// Converter control: registers, clock divider, sequencer, result format
// and analog routing. Assumes the core returns one result bit per
// conversion clock, MSB first, during the conversion phase.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module adcc_top (
    input  wire logic               i_core_clk,
    input  wire logic               i_rst,
    input  wire adcc_pkg::adcc_bus_t i_bus,
    output logic [7:0]              o_rdata,
    input  wire logic               i_core_bit,
    output adcc_pkg::adcc_route_t   o_route,
    output logic [7:0]              o_pin_analog,
    output logic [7:0]              o_pin_pull_dis,
    output logic [7:0]              o_pin_dir_ovr,
    output logic                    o_conv_busy,
    output logic                    o_irq
);
    import adcc_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]  converter_ctrl0;
    logic [7:0]  converter_ctrl1;
    logic [7:0]  converter_ctrl2;
    logic [7:0]  pin_func_sel0;
    logic        conv_irq_flag;
    logic        conv_irq_enable;
    logic        global_irq_enable;
    logic [11:0] result;
    logic [11:0] shift_acc;
    logic        conv_busy;
    logic        start_q;
    logic [6:0]  div_cnt;
    logic        tick;
    logic [4:0]  phase_cnt;
    logic        done;
    logic        core_bit_s1;
    logic        core_bit_s2;

    logic        result_format;
    logic [3:0]  channel_select;
    logic [3:0]  input_source_select;
    logic [2:0]  conv_clock_select;
    logic [1:0]  ref_select;
    logic        pga_input_select;
    logic        converter_power_enable;
    logic        start_bit;
    logic        start_fall;
    logic        wr_irq;
    logic [15:0] result_aligned;

    assign result_format          = converter_ctrl0[CTRL0_FMT_BIT];
    assign channel_select         = converter_ctrl0[CTRL0_CHAN_LSB +: 4];
    assign converter_power_enable = converter_ctrl0[CTRL0_PWR_BIT];
    assign start_bit              = converter_ctrl0[CTRL0_START_BIT];
    assign input_source_select    = converter_ctrl1[CTRL1_SRC_LSB +: 4];
    assign conv_clock_select      = converter_ctrl1[CTRL1_CLK_LSB +: 3];
    assign ref_select             = converter_ctrl2[CTRL2_REF_LSB +: 2];
    assign pga_input_select       = converter_ctrl2[CTRL2_PGA_INPUT_SELECT_BIT];
    assign wr_irq                 = i_bus.wr && (i_bus.addr == OFS_IRQ);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Source code to routing choice
    function automatic adcc_in_t decode_src(input logic [3:0] s);
        case (s)
            4'h1:    decode_src = ADCC_IN_SUP1;
            4'h2:    decode_src = ADCC_IN_SUP2;
            4'h3:    decode_src = ADCC_IN_SUP4;
            4'h5:    decode_src = ADCC_IN_PGA1;
            4'h6:    decode_src = ADCC_IN_PGA2;
            4'h7:    decode_src = ADCC_IN_PGA4;
            4'h8:    decode_src = ADCC_IN_AMP0;
            4'h9:    decode_src = ADCC_IN_AMP1;
            4'hA,
            4'hB:    decode_src = ADCC_IN_GND;
            default: decode_src = ADCC_IN_EXT;
        endcase
    endfunction

    // Divider terminal count: 2^code - 1
    function automatic logic [6:0] div_limit(input logic [2:0] c);
        div_limit = 7'(({7'h00, 1'b1} << c) - 8'h01);
    endfunction

    // Result laid across the two read bytes as {high, low}
    function automatic logic [15:0] align_result(input logic [11:0] r, input logic fmt);
        if (fmt)
            align_result = {4'h0, r};
        else
            align_result = {r, 4'h0};
    endfunction

    // ----------------------------------------------------------------
    // Control register writes
    // ----------------------------------------------------------------
    // Busy bit is read-only; start bit is software-owned
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            converter_ctrl0 <= RST_CTRL0;
            converter_ctrl1 <= RST_CTRL1;
            converter_ctrl2 <= RST_CTRL2;
            pin_func_sel0   <= RST_PINFUNC;
        end else if (i_bus.wr) begin
            case (i_bus.addr)
                OFS_CTRL0:   converter_ctrl0 <= i_bus.wdata & 8'hBF;
                OFS_CTRL1:   converter_ctrl1 <= i_bus.wdata & 8'hF7;
                OFS_CTRL2:   converter_ctrl2 <= i_bus.wdata & 8'h9F;
                OFS_PINFUNC: pin_func_sel0   <= i_bus.wdata;
                default: ;
            endcase
        end
    end

    // Interrupt enables, written as a pair
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            conv_irq_enable   <= 1'b0;
            global_irq_enable <= 1'b0;
        end else if (wr_irq) begin
            conv_irq_enable   <= i_bus.wdata[IRQ_ADE_BIT];
            global_irq_enable <= i_bus.wdata[IRQ_EMI_BIT];
        end
    end

    // Request flag; completion beats a software clear in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            conv_irq_flag <= 1'b0;
        else if (done)
            conv_irq_flag <= 1'b1;
        else if (wr_irq)
            conv_irq_flag <= i_bus.wdata[IRQ_FLAG_BIT];
    end

    // Interrupt output gated by both enables
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            o_irq <= 1'b0;
        else
            o_irq <= conv_irq_flag && conv_irq_enable && global_irq_enable;
    end

    // ----------------------------------------------------------------
    // Start detection
    // ----------------------------------------------------------------
    // A falling start bit after a rise completes the low-high-low pulse
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            start_q <= 1'b0;
        else
            start_q <= start_bit;
    end
    assign start_fall = start_q && !start_bit;

    // ----------------------------------------------------------------
    // Converter clock divider
    // ----------------------------------------------------------------
    // Tick marks one converter clock; restarted with each conversion
    // A new divider code applies at once to the count in progress
    always_ff @(posedge i_core_clk) begin
        if (i_rst || start_fall) begin
            div_cnt <= 7'h00;
            tick    <= 1'b0;
        end else if (div_cnt >= div_limit(conv_clock_select)) begin
            div_cnt <= 7'h00;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 7'h01;
            tick    <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Core bit crosses from the analog side, so it is synchronised
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            core_bit_s1 <= 1'b0;
            core_bit_s2 <= 1'b0;
        end else begin
            core_bit_s1 <= i_core_bit;
            core_bit_s2 <= core_bit_s1;
        end
    end

    // Runs beside the processor; a new start while busy restarts sampling
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            conv_busy <= 1'b0;
            phase_cnt <= 5'h00;
            shift_acc <= 12'h000;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start_fall && converter_power_enable) begin
                conv_busy <= 1'b1;
                phase_cnt <= 5'h00;
                shift_acc <= 12'h000;
            end else if (!converter_power_enable) begin
                conv_busy <= 1'b0;
                phase_cnt <= 5'h00;
            end else if (conv_busy && tick) begin
                if (phase_cnt >= SAMPLE_CYCLES)
                    shift_acc <= {shift_acc[10:0], core_bit_s2};
                if (phase_cnt == TOTAL_CYCLES - 5'h01) begin
                    conv_busy <= 1'b0;
                    done      <= 1'b1;
                    phase_cnt <= 5'h00;
                end else begin
                    phase_cnt <= phase_cnt + 5'h01;
                end
            end
        end
    end

    // Result captured only once the last bit is in
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            result <= 12'h000;
        else if (done)
            result <= shift_acc;
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    // Alignment follows the live format bit, so a held result is re-laid
    assign result_aligned = align_result(result, result_format);

    // One-cycle read latency; unmapped offsets read zero
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_bus.rd) begin
            case (i_bus.addr)
                OFS_CTRL0:   o_rdata <= {converter_ctrl0[7], conv_busy, converter_ctrl0[5:0]};
                OFS_CTRL1:   o_rdata <= converter_ctrl1;
                OFS_CTRL2:   o_rdata <= converter_ctrl2;
                OFS_RES_HI:  o_rdata <= result_aligned[15:8];
                OFS_RES_LO:  o_rdata <= result_aligned[7:0];
                OFS_IRQ:     o_rdata <= {5'h00, global_irq_enable, conv_irq_enable, conv_irq_flag};
                OFS_PINFUNC: o_rdata <= pin_func_sel0;
                default:     o_rdata <= 8'h00;
            endcase
        end else
            o_rdata <= 8'h00;
    end

    // Busy mirrored one cycle late; keeps the pin off any decode path
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            o_conv_busy <= 1'b0;
        else
            o_conv_busy <= conv_busy;
    end

    // ----------------------------------------------------------------
    // Analog routing
    // ----------------------------------------------------------------
    // Registered so the core sees glitch-free selects
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_route <= '0;
        end else begin
            case (ref_select)
                2'b00:   o_route.ref_sel <= ADCC_REF_SUPPLY;
                2'b01:   o_route.ref_sel <= ADCC_REF_PIN;
                default: o_route.ref_sel <= ADCC_REF_PGA;
            endcase
            o_route.ref_pin_en       <= (ref_select == 2'b01);
            o_route.pga_en           <= converter_ctrl2[CTRL2_PGAEN_BIT];
            o_route.pga_from_bandgap <= pga_input_select;
            o_route.pga_pin_en       <= !pga_input_select;
            o_route.pga_gain         <= converter_ctrl2[CTRL2_GAIN_LSB +: 2];
            o_route.in_sel           <= decode_src(input_source_select);
            // Internal source forces the external path off
            o_route.ext_path_en      <= (decode_src(input_source_select) == ADCC_IN_EXT);
            // Codes 8..15 leave every channel open, so the input floats
            o_route.ext_chan_onehot  <= (decode_src(input_source_select) == ADCC_IN_EXT && !channel_select[3])
                                        ? 8'(8'h01 << channel_select[2:0]) : 8'h00;
            o_route.power_on         <= converter_power_enable;
            // No sampling phase shows once power is dropped
            o_route.sample           <= conv_busy && converter_power_enable && (phase_cnt < SAMPLE_CYCLES);
        end
    end

    // Analog pin function: drop digital use, pull-high and direction
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pin_analog   <= 8'h00;
            o_pin_pull_dis <= 8'h00;
            o_pin_dir_ovr  <= 8'h00;
        end else begin
            o_pin_analog   <= pin_func_sel0;
            o_pin_pull_dis <= pin_func_sel0;
            o_pin_dir_ovr  <= pin_func_sel0;
        end
    end

endmodule

`default_nettype wire

// ==== bench/adcc_core_model.sv ====
// Behavioural analog core: returns one steady result bit while powered.
// Assumes the route bundle of the control block and the core clock.
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
    input  wire logic                  i_core_clk,
    input  wire adcc_pkg::adcc_route_t i_route,
    input  wire logic                  i_level,
    output logic                       o_core_bit
);
    initial o_core_bit = 1'b0;
    // An unpowered core drives nothing useful, so the bit keeps changing
    always @(posedge i_core_clk) begin
        if (i_route.power_on) begin
            o_core_bit <= i_level;
        end else begin
            o_core_bit <= ~o_core_bit;
        end
    end
endmodule
`default_nettype wire

// ==== bench/adcc_top_sva.sv ====
// Port assertions for the converter control block.
// Assumes one clock, synchronous active-high reset; attached by bind.
`timescale 1ns/1ps
`default_nettype none
module adcc_top_sva (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire adcc_pkg::adcc_bus_t   i_bus,
    input  wire logic [7:0]            o_rdata,
    input  wire logic                  i_core_bit,
    input  wire adcc_pkg::adcc_route_t o_route,
    input  wire logic [7:0]            o_pin_analog,
    input  wire logic [7:0]            o_pin_pull_dis,
    input  wire logic [7:0]            o_pin_dir_ovr,
    input  wire logic                  o_conv_busy,
    input  wire logic                  o_irq
);
    import adcc_pkg::*;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Busy shows two to four edges after the write that drops start
    sequence s_start_write;
        $past(i_bus.wr, 2) || $past(i_bus.wr, 3) || $past(i_bus.wr, 4);
    endsequence
    sequence s_full_run;
        $past(o_conv_busy, 16);
    endsequence
    chk_ext_path_off: assert property (o_route.in_sel != ADCC_IN_EXT |-> !o_route.ext_path_en)
        else $error("external path on with internal source");
    chk_chan_single: assert property ($onehot0(o_route.ext_chan_onehot))
        else $error("more than one channel selected");
    chk_ref_pin_only: assert property (o_route.ref_sel != ADCC_REF_PIN |-> !o_route.ref_pin_en)
        else $error("reference pin used with internal reference");
    chk_pga_pin_off: assert property (o_route.pga_from_bandgap |-> !o_route.pga_pin_en)
        else $error("gain stage pin used with bandgap input");
    chk_pull_disc: assert property (o_pin_pull_dis == o_pin_analog)
        else $error("pull-high kept on analog pin");
    chk_dir_override: assert property (o_pin_dir_ovr == o_pin_analog)
        else $error("direction not overridden on analog pin");
    chk_busy_start: assert property ($rose(o_conv_busy) |-> s_start_write)
        else $error("busy rose without a start write");
    chk_busy_len: assert property ($fell(o_conv_busy) |-> s_full_run)
        else $error("conversion shorter than sixteen clocks");
    chk_rdata_quiet: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
        else $error("read data outside read answer cycle");
    chk_sample_power: assert property (o_route.sample |-> o_route.power_on)
        else $error("sampling while converter unpowered");
endmodule
bind adcc_top adcc_top_sva adcc_top_sva_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_core_bit(i_core_bit), .o_route(o_route), .o_pin_analog(o_pin_analog),
    .o_pin_pull_dis(o_pin_pull_dis), .o_pin_dir_ovr(o_pin_dir_ovr),
    .o_conv_busy(o_conv_busy), .o_irq(o_irq)
);
`default_nettype wire

// ==== bench/adcc_top_tb.sv ====
// Self-checking bench for the converter control block and core model.
// Assumes a 25 MHz clock and the register map of the package.
`timescale 1ns/1ps
`default_nettype none
module adcc_top_tb;
    import adcc_pkg::*;
    typedef struct packed {
        logic [3:0] src;
        logic [3:0] ch;
        adcc_in_t   ein;
    } adcc_row_t;
    logic        clk;
    logic        rst;
    adcc_bus_t   bus;
    logic [7:0]  rdata;
    logic        core_bit;
    logic        level;
    adcc_route_t route;
    logic [7:0]  pin_an;
    logic [7:0]  pin_pd;
    logic [7:0]  pin_do;
    logic        busy;
    logic        irq;
    int          fail_count;
    int          samples_checked;
    int          cyc;
    adcc_ref_t   refs [4] = '{ADCC_REF_SUPPLY, ADCC_REF_PIN, ADCC_REF_PGA, ADCC_REF_PGA};
    adcc_row_t   rows [16] = '{'{4'h0, 4'h0, ADCC_IN_EXT}, '{4'h1, 4'h2, ADCC_IN_SUP1},
        '{4'h2, 4'h2, ADCC_IN_SUP2}, '{4'h3, 4'h2, ADCC_IN_SUP4}, '{4'h4, 4'h7, ADCC_IN_EXT},
        '{4'h5, 4'h2, ADCC_IN_PGA1}, '{4'h6, 4'h2, ADCC_IN_PGA2}, '{4'h7, 4'h2, ADCC_IN_PGA4},
        '{4'h8, 4'h2, ADCC_IN_AMP0}, '{4'h9, 4'h2, ADCC_IN_AMP1}, '{4'hA, 4'h2, ADCC_IN_GND},
        '{4'hB, 4'h2, ADCC_IN_GND}, '{4'hC, 4'h3, ADCC_IN_EXT}, '{4'hD, 4'h8, ADCC_IN_EXT},
        '{4'hE, 4'hF, ADCC_IN_EXT}, '{4'hF, 4'h5, ADCC_IN_EXT}};

    adcc_top adcc_top_inst (
        .i_core_clk(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata), .i_core_bit(core_bit),
        .o_route(route), .o_pin_analog(pin_an), .o_pin_pull_dis(pin_pd), .o_pin_dir_ovr(pin_do),
        .o_conv_busy(busy), .o_irq(irq)
    );
    adcc_core_model adcc_core_model_inst (
        .i_core_clk(clk), .i_route(route), .i_level(level), .o_core_bit(core_bit)
    );

    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Slowest divider needs about 2k clocks; anything far past that is a hang
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            $display("MISMATCH timeout expected 0 seen 1");
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask
    // Strobe lowered on the taking edge, so the next call starts an edge later
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '{3'h0, 8'h00, 1'b0, 1'b0};
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '{3'h0, 8'h00, 1'b0, 1'b0};
        @(negedge clk);
        chk(nm, {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic start(input logic [7:0] c0);
        wr(OFS_CTRL0, c0 | 8'h80);
        wr(OFS_CTRL0, c0);
    endtask
    task automatic wait_busy(input logic lvl);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (busy !== lvl && k < 6000);
        chk("busy_wait", {15'h0, lvl}, {15'h0, busy});
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [2:0]  kb;
        logic [11:0] res;
        logic        seen;
        int          t0;
        int          n;
        bus = '0;
        level = 1'b0;
        rst = 1'b1;
        fail_count = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Routing table: every source code, reference code and both gain inputs
        foreach (rows[i]) begin
            wr(OFS_CTRL1, {rows[i].src, 4'h0});
            wr(OFS_CTRL2, {3'h4, rows[i].src[0], rows[i].src[1:0], 2'h0});
            wr(OFS_CTRL0, {4'h2, rows[i].ch});
            repeat (3) @(negedge clk);
            chk("in_sel", {12'h0, rows[i].ein}, {12'h0, route.in_sel});
            chk("ref_sel", {14'h0, refs[rows[i].src[1:0]]}, {14'h0, route.ref_sel});
            chk("ref_pin", {15'h0, refs[rows[i].src[1:0]] == ADCC_REF_PIN}, {15'h0, route.ref_pin_en});
            chk("pga_bg", {15'h0, rows[i].src[0]}, {15'h0, route.pga_from_bandgap});
            chk("pga_pin", {15'h0, !rows[i].src[0]}, {15'h0, route.pga_pin_en});
            chk("pga_en", 16'h0001, {15'h0, route.pga_en});
            if (rows[i].ein == ADCC_IN_EXT) begin
                chk("ext_on", 16'h0001, {15'h0, route.ext_path_en});
                chk("chan", {8'h00, rows[i].ch[3] ? 8'h00 : 8'h01 << rows[i].ch[2:0]},
                    {8'h00, route.ext_chan_onehot});
            end else begin
                chk("ext_off", 16'h0000, {15'h0, route.ext_path_en});
            end
        end
        // One conversion per divider code, varying format, level and enables
        for (int k = 0; k < 8; k++) begin
            kb = 3'(k);
            res = (kb[1] ^ kb[0]) ? 12'hFFF : 12'h000;
            @(posedge clk);
            level <= kb[1] ^ kb[0];
            wr(OFS_IRQ, {5'h00, kb[2:1], 1'b0});
            wr(OFS_CTRL1, {5'h00, kb});
            start({3'h1, kb[0], 4'h0});
            wait_busy(1'b1);
            t0 = cyc;
            rd(OFS_CTRL0, {3'h3, kb[0], 4'h0}, "ctrl0_busy");
            wait_busy(1'b0);
            n = cyc - t0;
            chk("busy_len", 16'h0001, {15'h0, n >= (16 << k) && n <= (16 << k) + 2});
            repeat (3) @(negedge clk);
            chk("irq_out", {15'h0, &kb[2:1]}, {15'h0, irq});
            rd(OFS_IRQ, {5'h00, kb[2:1], 1'b1}, "irq_flag");
            rd(OFS_RES_HI, kb[0] ? {4'h0, res[11:8]} : res[11:4], "res_hi");
            rd(OFS_RES_LO, kb[0] ? res[7:0] : {res[3:0], 4'h0}, "res_lo");
            wr(OFS_IRQ, {5'h00, kb[2:1], 1'b0});
            rd(OFS_IRQ, {5'h00, kb[2:1], 1'b0}, "irq_clear");
        end
        // Second start in mid-run must stretch busy past sixteen clocks
        wr(OFS_CTRL1, 8'h00);
        start(8'h20);
        wait_busy(1'b1);
        t0 = cyc;
        start(8'h20);
        wait_busy(1'b0);
        n = cyc - t0;
        chk("restart_len", 16'h0001, {15'h0, n > 18 && n < 28});
        // Start with the converter unpowered is ignored
        wr(OFS_CTRL0, 8'h00);
        start(8'h00);
        seen = 1'b0;
        repeat (20) begin
            @(negedge clk);
            seen = seen | busy;
        end
        chk("busy_unpowered", 16'h0000, {15'h0, seen});
        chk("power_off", 16'h0000, {15'h0, route.power_on});
        // Pin function, read-only busy bit and an unmapped offset
        wr(OFS_PINFUNC, 8'hA5);
        repeat (3) @(negedge clk);
        chk("pull_dis", 16'h00A5, {8'h00, pin_pd});
        chk("dir_ovr", 16'h00A5, {8'h00, pin_do});
        chk("pin_an", 16'h00A5, {8'h00, pin_an});
        wr(OFS_CTRL0, 8'h40);
        rd(OFS_CTRL0, RST_CTRL0, "busy_ro");
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h00, "unmapped");
        rd(OFS_PINFUNC, 8'hA5, "pinfunc");
        // Reset in mid-conversion clears busy, routing, pins and controls
        wr(OFS_CTRL1, 8'h07);
        start(8'h20);
        wait_busy(1'b1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("rst_busy", 16'h0000, {15'h0, busy});
        chk("rst_power", 16'h0000, {15'h0, route.power_on});
        chk("rst_pin", 16'h0000, {8'h00, pin_an});
        rd(OFS_CTRL1, RST_CTRL1, "rst_ctrl1");
        give_verdict();
    end
endmodule
`default_nettype wire
